// ==== sxs_map.svh ====
// Offsets, field positions, reset values and counts of the ALU block.
// Assumes an APB master with 32-bit data and byte addresses.
//
// Functional notes
// - Literal minus accumulator, result to accumulator.
// - Literal subtract: carry and nibble flags as no-borrow, and zero.
// - Register minus accumulator, destination bit selects target.
// - Register subtract: carry, nibble and zero flags.
// - Literal exclusive-OR into accumulator, zero only.
// - Nibble exchange of register, no flag changes.
// - Register exclusive-OR, destination selects, zero only.
`ifndef SXS_MAP_SVH
`define SXS_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SXS_ADDR_CMD 12'h000
`define SXS_ADDR_ACC 12'h004
`define SXS_ADDR_STAT 12'h008
`define SXS_FILE_BASE_HI 3'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SXS_CMD_OP_LSB 0
`define SXS_CMD_DEST_BIT 3
`define SXS_CMD_ADDR_LSB 4
`define SXS_CMD_LIT_LSB 16
`define SXS_STAT_CARRY 0
`define SXS_STAT_NIB 1
`define SXS_STAT_ZERO 2

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define SXS_ACC_RST 8'h00
`define SXS_FILE_RST 8'h00
`define SXS_FLAG_RST 1'b0
`define SXS_FILE_DEPTH 128

`endif

// ==== sxs_pkg.sv ====
// Types shared by the ALU block.
// Assumes sxs_map.svh is compiled alongside.
package sxs_pkg;

    // Operation codes carried in the command register.
    typedef enum logic [2:0] {
        sxs_op_literal_minus_acc = 3'h1,
        sxs_op_reg_minus_acc = 3'h2,
        sxs_op_literal_exor_acc = 3'h3,
        sxs_op_reg_exor_acc = 3'h4,
        sxs_op_nibble_exchange_op = 3'h5
    } sxs_op_t;

endpackage

// ==== sxs_alu.sv ====
// Subtract, exclusive-OR and nibble-exchange datapath with APB access.
// Assumes an APB master on pclk; one transfer at a time, full words.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "sxs_map.svh"

module sxs_alu
    import sxs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] acc_value,
    output logic carry_flag,
    output logic low_nibble_borrow_inv,
    output logic zero_flag
);

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // One wait state: pready comes from a flop, so every access
    // takes setup plus two access cycles.
    logic [7:0] file_mem [`SXS_FILE_DEPTH];
    wire acc_phase = psel & penable;
    wire xfer_ok = acc_phase & pready;
    wire wr_ok = xfer_ok & pwrite;
    wire sel_cmd = paddr == `SXS_ADDR_CMD;
    wire sel_acc = paddr == `SXS_ADDR_ACC;
    wire sel_stat = paddr == `SXS_ADDR_STAT;
    wire sel_file = (paddr[11:9] == `SXS_FILE_BASE_HI)
        & (paddr[1:0] == 2'h0);
    wire sel_hit = sel_cmd | sel_acc | sel_stat | sel_file;
    wire [6:0] file_idx = paddr[8:2];
    wire [7:0] file_rd = file_mem[file_idx];
    wire [31:0] stat_word = {29'h0, zero_flag,
        low_nibble_borrow_inv, carry_flag};
    wire [31:0] next_prdata = pwrite ? 32'h0 :
        sel_acc ? {24'h0, acc_value} :
        sel_stat ? stat_word :
        sel_file ? {24'h0, file_rd} : 32'h0;
    wire next_pready = acc_phase & ~pready;
    // A back-to-back setup after an access sees pready low again,
    // so each transfer gets its own wait state.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= next_pready;
            pslverr <= next_pready & ~sel_hit;
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // Command fields
    // ------------------------------------------------------------
    wire cmd_wr = wr_ok & sel_cmd;
    wire [2:0] op_code = pwdata[`SXS_CMD_OP_LSB +: 3];
    wire dest = pwdata[`SXS_CMD_DEST_BIT];
    wire [6:0] op_addr = pwdata[`SXS_CMD_ADDR_LSB +: 7];
    wire [7:0] literal = pwdata[`SXS_CMD_LIT_LSB +: 8];
    wire is_sub_lit = op_code == sxs_op_literal_minus_acc;
    wire is_sub_reg = op_code == sxs_op_reg_minus_acc;
    wire is_xor_lit = op_code == sxs_op_literal_exor_acc;
    wire is_xor_reg = op_code == sxs_op_reg_exor_acc;
    wire is_swap = op_code == sxs_op_nibble_exchange_op;
    wire uses_lit = is_sub_lit | is_xor_lit;
    wire is_sub = is_sub_lit | is_sub_reg;
    wire is_xor = is_xor_lit | is_xor_reg;
    wire op_valid = is_sub | is_xor | is_swap;

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    // Operands are taken as they stand before the edge, so a result
    // written back to a file register is seen by the next command.
    wire [7:0] file_op = file_mem[op_addr];
    wire [7:0] operand = uses_lit ? literal : file_op;
    // Two's complement difference; bit 8 is the borrow out.
    wire [8:0] diff = {1'b0, operand} - {1'b0, acc_value};
    wire [4:0] nib_diff = {1'b0, operand[3:0]}
        - {1'b0, acc_value[3:0]};
    wire next_carry = ~diff[8];
    wire next_nib = ~nib_diff[4];
    wire [7:0] xor_res = acc_value ^ operand;
    wire [7:0] swap_res = {file_op[3:0], file_op[7:4]};
    wire [7:0] result = is_sub ? diff[7:0] :
        is_xor ? xor_res : swap_res;
    wire next_zero = result == 8'h00;

    // Literal forms ignore the destination bit and always go to
    // the accumulator.
    wire to_file = cmd_wr & op_valid & ~uses_lit & dest;
    wire op_to_acc = cmd_wr & op_valid & ~to_file;
    wire acc_we = op_to_acc | (wr_ok & sel_acc);
    wire [7:0] next_acc = op_to_acc ? result : pwdata[7:0];
    wire stat_we = wr_ok & sel_stat;
    wire carry_we = cmd_wr & is_sub;
    wire zero_we = cmd_wr & (is_sub | is_xor);

    // ------------------------------------------------------------
    // Accumulator and status flags
    // ------------------------------------------------------------
    // An operation and a status write never share a cycle, since
    // each needs its own APB transfer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_value <= `SXS_ACC_RST;
            carry_flag <= `SXS_FLAG_RST;
            low_nibble_borrow_inv <= `SXS_FLAG_RST;
            zero_flag <= `SXS_FLAG_RST;
        end else begin
            if (acc_we) begin
                acc_value <= next_acc;
            end
            if (carry_we) begin
                carry_flag <= next_carry;
                low_nibble_borrow_inv <= next_nib;
            end else if (stat_we) begin
                carry_flag <= pwdata[`SXS_STAT_CARRY];
                low_nibble_borrow_inv <= pwdata[`SXS_STAT_NIB];
            end
            if (zero_we) begin
                zero_flag <= next_zero;
            end else if (stat_we) begin
                zero_flag <= pwdata[`SXS_STAT_ZERO];
            end
        end
    end

    // ------------------------------------------------------------
    // File register storage
    // ------------------------------------------------------------
    // The operation port wins over a bus write to the same entry;
    // both cannot arrive together, as each needs its own transfer.
    for (genvar i = 0; i < `SXS_FILE_DEPTH; i++) begin : g_file
        wire bus_we = wr_ok & sel_file & (file_idx == 7'(i));
        wire alu_we = to_file & (op_addr == 7'(i));
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                file_mem[i] <= `SXS_FILE_RST;
            end else if (alu_we) begin
                file_mem[i] <= result;
            end else if (bus_we) begin
                file_mem[i] <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire go_sub_lit = cmd_wr & is_sub_lit;
    wire go_sub_reg = cmd_wr & is_sub_reg;
    wire go_xor_lit = cmd_wr & is_xor_lit;
    wire go_xor_reg = cmd_wr & is_xor_reg;
    wire go_swap = cmd_wr & is_swap;

    sub_lit_value_a: assert property (
        go_sub_lit |=> acc_value ==
            8'($past(literal) - $past(acc_value)))
        else $error("literal subtract result wrong");

    sub_lit_flags_a: assert property (
        go_sub_lit |=>
            carry_flag == ($past(acc_value) <= $past(literal)) &&
            low_nibble_borrow_inv ==
            ($past(acc_value[3:0]) <= $past(literal[3:0])))
        else $error("literal subtract flags wrong");

    sub_reg_dest_a: assert property (
        go_sub_reg && dest |=>
            file_mem[$past(op_addr)] ==
            8'($past(file_op) - $past(acc_value)) &&
            $stable(acc_value))
        else $error("register subtract write-back wrong");

    sub_reg_flags_a: assert property (
        go_sub_reg |=>
            carry_flag == ($past(acc_value) <= $past(file_op)) &&
            low_nibble_borrow_inv ==
            ($past(acc_value[3:0]) <= $past(file_op[3:0])))
        else $error("register subtract flags wrong");

    xor_lit_only_z_a: assert property (
        go_xor_lit |=> acc_value ==
            ($past(acc_value) ^ $past(literal)) &&
            $stable(carry_flag) && $stable(low_nibble_borrow_inv))
        else $error("literal exclusive-OR wrong");

    swap_no_flag_a: assert property (
        go_swap |=> $stable(carry_flag) && $stable(zero_flag) &&
            $stable(low_nibble_borrow_inv))
        else $error("nibble exchange touched a flag");

    swap_value_a: assert property (
        go_swap && !dest |=> acc_value ==
            {$past(file_op[3:0]), $past(file_op[7:4])})
        else $error("nibble exchange result wrong");

    xor_reg_dest_a: assert property (
        go_xor_reg && !dest |=> acc_value ==
            ($past(acc_value) ^ $past(file_op)) &&
            $stable(carry_flag))
        else $error("register exclusive-OR wrong");

    zero_flag_a: assert property (
        zero_we |=> zero_flag == ($past(result) == 8'h00))
        else $error("zero flag does not match result");

    apb_ready_a: assert property (
        acc_phase && !pready |=> pready ##1 !pready)
        else $error("ready not a single cycle");

    // ------------------------------------------------------------
    // Destination, hold, bus write and APB checks
    // ------------------------------------------------------------
    // These catch a write that lands on the wrong side of the
    // destination bit, which the value checks above cannot see.
    sub_reg_acc_a: assert property (
        go_sub_reg && !dest |=> acc_value ==
            8'($past(file_op) - $past(acc_value)))
        else $error("register subtract to accumulator wrong");

    swap_file_a: assert property (
        go_swap && dest |=>
            file_mem[$past(op_addr)] ==
            {$past(file_op[3:0]), $past(file_op[7:4])} &&
            $stable(acc_value))
        else $error("nibble exchange write-back wrong");

    xor_reg_file_a: assert property (
        go_xor_reg && dest |=>
            file_mem[$past(op_addr)] ==
            ($past(acc_value) ^ $past(file_op)) &&
            $stable(acc_value) && $stable(carry_flag) &&
            $stable(low_nibble_borrow_inv))
        else $error("register exclusive-OR write-back wrong");

    xor_lit_zero_a: assert property (
        go_xor_lit |=> zero_flag ==
            (($past(acc_value) ^ $past(literal)) == 8'h00))
        else $error("literal exclusive-OR zero flag wrong");

    // An ignored code must not disturb anything, or software that
    // probes spare codes would corrupt its own state.
    bad_op_hold_a: assert property (
        cmd_wr && !op_valid |=> $stable(acc_value) &&
            $stable(carry_flag) && $stable(zero_flag) &&
            $stable(low_nibble_borrow_inv))
        else $error("ignored command changed state");

    acc_hold_a: assert property (
        !acc_we |=> $stable(acc_value))
        else $error("accumulator changed without a write");

    carry_hold_a: assert property (
        !carry_we && !stat_we |=> $stable(carry_flag) &&
            $stable(low_nibble_borrow_inv))
        else $error("carry flags changed without a cause");

    zero_hold_a: assert property (
        !zero_we && !stat_we |=> $stable(zero_flag))
        else $error("zero flag changed without a cause");

    file_bus_wr_a: assert property (
        wr_ok && sel_file |=> file_mem[$past(file_idx)] ==
            $past(pwdata[7:0]))
        else $error("file register bus write lost");

    stat_bus_wr_a: assert property (
        stat_we |=> zero_flag == $past(pwdata[`SXS_STAT_ZERO]) &&
            carry_flag == $past(pwdata[`SXS_STAT_CARRY]))
        else $error("status write lost");

    apb_err_a: assert property (
        pslverr |-> pready)
        else $error("error without ready");

    // An unmapped or write-only location reads as zero.
    apb_rdata_a: assert property (
        pready && !(sel_acc || sel_stat || sel_file) |-> prdata == 32'h0)
        else $error("unmapped read returned data");

    cov_sub_borrow_c: cover property (go_sub_lit && diff[8]);
    cov_sub_to_file_c: cover property (go_sub_reg && dest);
    cov_xor_zero_c: cover property (go_xor_reg && next_zero);
    cov_swap_c: cover property (go_swap ##[2:16] go_swap);
    cov_bad_op_c: cover property (cmd_wr && !op_valid);

endmodule

// ==== sxs_host_model.sv ====
// Instruction side of the ALU: runs one APB transfer for each call.
// Assumes a single caller; each transfer opens on a rising pclk edge.
`timescale 1ns/1ps

module sxs_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ----
    // Transfer
    // ----
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // Stale write data is inverted so a late sample never looks right.
    task automatic xfer(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

// ==== tb_top.sv ====
// Bench for the ALU: commands over APB, checked against a reference.
// Assumes sxs_map.svh, sxs_pkg and sxs_host_model are compiled first.
`timescale 1ns/1ps

module tb_top;
    import sxs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] acc_value, m_acc, m_mem[128];
    logic carry_flag, low_nibble_borrow_inv, zero_flag, m_c, m_dc, m_z;
    int n_mismatch = 0;
    int num_checks = 0;

    sxs_alu dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .acc_value(acc_value), .carry_flag(carry_flag),
        .low_nibble_borrow_inv(low_nibble_borrow_inv), .zero_flag(zero_flag));
    sxs_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // ----
    // Tasks
    // ----
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] x, g);
        num_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    function automatic logic [11:0] fa(input logic [6:0] f);
        return 12'h200 + {3'h0, f, 2'h0};
    endfunction

    task automatic rw(input logic wr, input logic [11:0] a, input logic [31:0] d);
        host.xfer(wr, a, d, q, e);
        #1;
    endtask

    task automatic state();
        chk("acc", {24'h0, m_acc}, {24'h0, acc_value});
        chk("flags", {29'h0, m_z, m_dc, m_c},
            {29'h0, zero_flag, low_nibble_borrow_inv, carry_flag});
    endtask

    task automatic wf(input logic [6:0] f, input logic [7:0] v);
        rw(1'b1, fa(f), {24'h0, v});
        m_mem[f] = v;
    endtask

    task automatic wa(input logic [7:0] v);
        rw(1'b1, 12'h004, {24'h0, v});
        m_acc = v;
    endtask

    // Invalid codes must leave every value untouched.
    task automatic op(input logic [2:0] o, input logic d, input logic [6:0] f,
        input logic [7:0] k);
        logic lit;
        logic [7:0] s;
        logic [7:0] r;
        lit = o == sxs_op_literal_minus_acc || o == sxs_op_literal_exor_acc;
        s = lit ? k : m_mem[f];
        r = {s[3:0], s[7:4]};
        if (o == sxs_op_literal_minus_acc || o == sxs_op_reg_minus_acc) begin
            r = s - m_acc;
            m_c = m_acc <= s;
            m_dc = m_acc[3:0] <= s[3:0];
        end
        if (o == sxs_op_literal_exor_acc || o == sxs_op_reg_exor_acc) begin
            r = s ^ m_acc;
        end
        if (o != 3'h0 && o < 3'h6 && o != sxs_op_nibble_exchange_op) begin
            m_z = r == 8'h00;
        end
        if (o != 3'h0 && o < 3'h6) begin
            if (d && !lit) m_mem[f] = r;
            else m_acc = r;
        end
        rw(1'b1, 12'h000, {8'h00, k, 5'h00, f, d, o});
        state();
        rw(1'b0, fa(f), 32'h0);
        chk("file", {24'h0, m_mem[f]}, q);
        chk("err", 32'h0, {31'h0, e});
    endtask

    // ----
    // Tests
    // ----
    initial begin
        presetn = 1'b0;
        for (int i = 0; i < 128; i++) m_mem[i] = 8'h00;
        {m_acc, m_c, m_dc, m_z} = 11'h000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        state();
        $display("test reset done");
        wa(8'h5A);
        op(sxs_op_literal_minus_acc, 1'b1, 7'd3, 8'h5A);
        op(sxs_op_literal_minus_acc, 1'b0, 7'd3, 8'hFF);
        op(sxs_op_literal_minus_acc, 1'b0, 7'd3, 8'h0F);
        wa(8'h0F);
        op(sxs_op_literal_minus_acc, 1'b0, 7'd3, 8'h10);
        $display("test literal subtract done");
        wf(7'd127, 8'h20);
        op(sxs_op_reg_minus_acc, 1'b1, 7'd127, 8'h00);
        op(sxs_op_reg_minus_acc, 1'b0, 7'd0, 8'h00);
        wf(7'd9, 8'hFF);
        op(sxs_op_reg_minus_acc, 1'b0, 7'd9, 8'h00);
        $display("test register subtract done");
        wa(8'hC3);
        op(sxs_op_literal_exor_acc, 1'b1, 7'd9, 8'hC3);
        op(sxs_op_literal_exor_acc, 1'b0, 7'd9, 8'h3C);
        op(sxs_op_reg_exor_acc, 1'b1, 7'd127, 8'h00);
        op(sxs_op_reg_exor_acc, 1'b0, 7'd127, 8'h00);
        $display("test exclusive-or done");
        rw(1'b1, 12'h008, 32'h0000_0005);
        {m_z, m_dc, m_c} = 3'b101;
        op(sxs_op_nibble_exchange_op, 1'b1, 7'd127, 8'h00);
        op(sxs_op_nibble_exchange_op, 1'b0, 7'd127, 8'h00);
        op(3'h0, 1'b0, 7'd127, 8'h44);
        op(3'h7, 1'b1, 7'd127, 8'h44);
        rw(1'b0, 12'h008, 32'h0);
        chk("stat", 32'h0000_0005, q);
        $display("test exchange done");
        rw(1'b0, 12'h004, 32'h0);
        chk("acc rd", {24'h0, m_acc}, q);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 128; i++) m_mem[i] = 8'h00;
        {m_acc, m_c, m_dc, m_z} = 11'h000;
        @(posedge pclk);
        #1;
        state();
        rw(1'b0, fa(7'd127), 32'h0);
        chk("file rst", 32'h0, q);
        $display("test mid reset done");
        rw(1'b0, 12'h00C, 32'h0);
        chk("err", 32'h1, {31'h0, e});
        chk("rdata", 32'h0, q);
        rw(1'b1, 12'h100, 32'h0000_00AA);
        chk("err", 32'h1, {31'h0, e});
        state();
        $display("test unmapped done");
        close_out();
    end

    // The tests take well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        close_out();
    end
endmodule
